/* sms_host_model.sv */
// Host controller model driving the three control pins of the block.
// Assumes the bench sets ON requests right after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module sms_host_model (
  // Clock
  input wire logic clk_sys,
  // Requests, true means ON
  input wire sms_pkg::sms_pins_t req,
  // Pins, low means ON
  output logic mode_switch_input_n,
  output logic fwd_limit_select_n,
  output logic rev_limit_select_n
);
  initial
  begin
    mode_switch_input_n = 1'b1;
    fwd_limit_select_n = 1'b1;
    rev_limit_select_n = 1'b1;
  end

  // Pins follow the request one edge later, pulled low for ON
  always @(posedge clk_sys)
  begin
    mode_switch_input_n <= !req.mode_switch_input;
    fwd_limit_select_n <= !req.fwd_limit_select;
    rev_limit_select_n <= !req.rev_limit_select;
  end
endmodule
`default_nettype wire

/* sms_mode_torque_sel.sv */
// Control-mode selection, preset-speed selection and torque limiting.
// Assumes active-low pins from the host controller, APB from software.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Combination setting accepts codes 4 through B, each pairing two modes.
// - Codes 4, 5, 6 decide mode from mode switch and both limit selects.
// - Mode switch on picks preset index 4 to 7 (index 4 gives zero speed) and reverse travel.
// - Codes 7, 8, 9: switch on gives speed/torque/speed, off position/position/torque.
// - Code A toggles zero clamp on speed; code B toggles pulse prohibition.
// - Forward and reverse internal limits in percent of rated torque.
// - Any applied limit above motor maximum is clipped to that maximum.
// - Forward select on applies forward external limit, else forward internal.
// - Reverse select on applies reverse external limit, else reverse internal.
// - External limits accept 0 to 400, default 100, effective at once.
// - Torque-limited output asserted while output torque is being limited.
module sms_mode_torque_sel (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host controller pins, active low
  input wire logic mode_switch_input_n,
  input wire logic fwd_limit_select_n,
  input wire logic rev_limit_select_n,
  // Torque path
  input wire logic signed [10:0] torque_req,
  output logic signed [10:0] torque_out,
  output logic torque_limited_flag_n,
  // Mode outputs
  output var sms_pkg::sms_sel_t sel_out,
  output logic [15:0] preset_speed,
  output logic [8:0] fwd_limit_applied,
  output logic [8:0] rev_limit_applied
);

  // Register file
  logic [3:0] comb_cfg_reg;
  logic [3:0] comb_act_reg;
  logic restart_reg;
  logic [8:0] fwd_int_reg;
  logic [8:0] rev_int_reg;
  logic [8:0] fwd_ext_reg;
  logic [8:0] rev_ext_reg;
  logic [8:0] motor_max_reg;
  logic [15:0] preset5_reg;
  logic [15:0] preset6_reg;
  logic [15:0] preset7_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic signed [10:0] torque_out_reg;
  logic limited_n_reg;
  sms_pkg::sms_sel_t sel_reg;
  logic [15:0] preset_speed_reg;
  logic [8:0] fwd_lim_reg;
  logic [8:0] rev_lim_reg;

  // Clamp a written limit to the accepted range
  function automatic logic [8:0] sat_lim(input logic [31:0] v);
    sat_lim = (v > 32'(sms_pkg::SMS_LIM_MAX)) ? sms_pkg::SMS_LIM_MAX : v[8:0];
  endfunction

  function automatic logic comb_ok(input logic [3:0] c);
    comb_ok = (c >= sms_pkg::SMS_COMB_MIN) && (c <= sms_pkg::SMS_COMB_MAX);
  endfunction

  // Mode and preset decode from combination and inputs
  function automatic sms_pkg::sms_sel_t decode_sel(input logic [3:0] c,
                                                   input sms_pkg::sms_pins_t p);
    sms_pkg::sms_sel_t s;
    s.mode = sms_pkg::SMS_MD_SPEED;
    s.preset_index = 3'h0;
    s.reverse_dir = 1'b0;
    case (c)
      4'h4, 4'h5, 4'h6:
      begin
        if (!p.mode_switch_input && !p.fwd_limit_select && !p.rev_limit_select)
        begin
          s.mode = (c == 4'h4) ? sms_pkg::SMS_MD_SPEED :
                   (c == 4'h5) ? sms_pkg::SMS_MD_POSITION : sms_pkg::SMS_MD_TORQUE;
        end
        else
        begin
          s.mode = sms_pkg::SMS_MD_PRESET;
          s.preset_index = {p.mode_switch_input, p.fwd_limit_select, p.rev_limit_select};
          s.reverse_dir = p.mode_switch_input;
        end
      end
      4'h7:
        s.mode = p.mode_switch_input ? sms_pkg::SMS_MD_SPEED : sms_pkg::SMS_MD_POSITION;
      4'h8:
        s.mode = p.mode_switch_input ? sms_pkg::SMS_MD_TORQUE : sms_pkg::SMS_MD_POSITION;
      4'h9:
        s.mode = p.mode_switch_input ? sms_pkg::SMS_MD_SPEED : sms_pkg::SMS_MD_TORQUE;
      4'ha:
        s.mode = p.mode_switch_input ? sms_pkg::SMS_MD_ZERO_CLAMP : sms_pkg::SMS_MD_SPEED;
      4'hb:
        s.mode = p.mode_switch_input ? sms_pkg::SMS_MD_POS_INHIBIT : sms_pkg::SMS_MD_POSITION;
      default:
        s.mode = sms_pkg::SMS_MD_SPEED;
    endcase
    decode_sel = s;
  endfunction

  // Pin synchroniser, inputs inverted after the second stage
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end
    else
    begin
      sync1_reg <= {mode_switch_input_n, fwd_limit_select_n, rev_limit_select_n};
      sync2_reg <= sync1_reg;
    end
  end

  wire sms_pkg::sms_pins_t pins_on = ~sync2_reg;

  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pready_reg && pwrite;
  wire [31:0] wval = pwdata;
  wire wr_mode = apb_wr && (paddr == sms_pkg::SMS_OFS_MODE_CFG);
  wire wr_restart = apb_wr && (paddr == sms_pkg::SMS_OFS_RESTART);
  wire addr_hit = (paddr <= sms_pkg::SMS_OFS_STATUS) && (paddr[1:0] == 2'b00);
  wire bad_wr = pwrite && ((paddr == sms_pkg::SMS_OFS_STATUS) ||
                (paddr == sms_pkg::SMS_OFS_MODE_CFG && !comb_ok(wval[3:0])));

  // Applied limits
  wire [8:0] fwd_pick = pins_on.fwd_limit_select ? fwd_ext_reg : fwd_int_reg;
  wire [8:0] rev_pick = pins_on.rev_limit_select ? rev_ext_reg : rev_int_reg;
  wire [8:0] fwd_lim = (fwd_pick > motor_max_reg) ? motor_max_reg : fwd_pick;
  wire [8:0] rev_lim = (rev_pick > motor_max_reg) ? motor_max_reg : rev_pick;

  wire signed [10:0] fwd_lim_s = $signed({2'b00, fwd_lim});
  wire signed [10:0] rev_lim_s = -$signed({2'b00, rev_lim});
  wire over_fwd = torque_req > fwd_lim_s;
  wire over_rev = torque_req < rev_lim_s;
  wire signed [10:0] torque_clip = over_fwd ? fwd_lim_s : over_rev ? rev_lim_s : torque_req;

  wire sms_pkg::sms_sel_t sel_next = decode_sel(comb_act_reg, pins_on);
  wire [15:0] preset_next = (sel_next.preset_index == 3'h5) ? preset5_reg :
                            (sel_next.preset_index == 3'h6) ? preset6_reg :
                            (sel_next.preset_index == 3'h7) ? preset7_reg : 16'h0000;

  wire [31:0] status_word = (32'(sel_reg.mode) << sms_pkg::SMS_STS_MODE_LSB) |
                            (32'(sel_reg.preset_index) << sms_pkg::SMS_STS_PRESET_LSB) |
                            (32'(sel_reg.reverse_dir) << sms_pkg::SMS_STS_REV_BIT) |
                            (32'(!limited_n_reg) << sms_pkg::SMS_STS_LIMITED_BIT) |
                            (32'(comb_act_reg) << sms_pkg::SMS_STS_COMB_LSB) |
                            (32'(fwd_lim_reg) << sms_pkg::SMS_STS_FWDLIM_LSB);

  wire [31:0] rd_mux = (paddr == sms_pkg::SMS_OFS_MODE_CFG) ? 32'(comb_cfg_reg) :
                       (paddr == sms_pkg::SMS_OFS_FWD_INT) ? 32'(fwd_int_reg) :
                       (paddr == sms_pkg::SMS_OFS_REV_INT) ? 32'(rev_int_reg) :
                       (paddr == sms_pkg::SMS_OFS_FWD_EXT) ? 32'(fwd_ext_reg) :
                       (paddr == sms_pkg::SMS_OFS_REV_EXT) ? 32'(rev_ext_reg) :
                       (paddr == sms_pkg::SMS_OFS_MOTOR_MAX) ? 32'(motor_max_reg) :
                       (paddr == sms_pkg::SMS_OFS_PRESET5) ? 32'(preset5_reg) :
                       (paddr == sms_pkg::SMS_OFS_PRESET6) ? 32'(preset6_reg) :
                       (paddr == sms_pkg::SMS_OFS_PRESET7) ? 32'(preset7_reg) :
                       (paddr == sms_pkg::SMS_OFS_STATUS) ? status_word : 32'h0000_0000;

  // APB answer: data and response prepared in the setup cycle
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup && (!addr_hit || bad_wr);
      prdata_reg <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Writable registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      comb_cfg_reg <= sms_pkg::SMS_RST_COMB;
      fwd_int_reg <= sms_pkg::SMS_RST_FWD_INT;
      rev_int_reg <= sms_pkg::SMS_RST_REV_INT;
      fwd_ext_reg <= sms_pkg::SMS_RST_EXT;
      rev_ext_reg <= sms_pkg::SMS_RST_EXT;
      motor_max_reg <= sms_pkg::SMS_RST_MOTOR_MAX;
      preset5_reg <= sms_pkg::SMS_RST_PRESET;
      preset6_reg <= sms_pkg::SMS_RST_PRESET;
      preset7_reg <= sms_pkg::SMS_RST_PRESET;
    end
    else if (apb_wr)
    begin
      if (paddr == sms_pkg::SMS_OFS_MODE_CFG && comb_ok(wval[3:0]))
        comb_cfg_reg <= wval[3:0];
      if (paddr == sms_pkg::SMS_OFS_FWD_INT)
        fwd_int_reg <= sat_lim(wval);
      if (paddr == sms_pkg::SMS_OFS_REV_INT)
        rev_int_reg <= sat_lim(wval);
      if (paddr == sms_pkg::SMS_OFS_FWD_EXT)
        fwd_ext_reg <= sat_lim(wval);
      if (paddr == sms_pkg::SMS_OFS_REV_EXT)
        rev_ext_reg <= sat_lim(wval);
      if (paddr == sms_pkg::SMS_OFS_MOTOR_MAX)
        motor_max_reg <= sat_lim(wval);
      if (paddr == sms_pkg::SMS_OFS_PRESET5)
        preset5_reg <= wval[15:0];
      if (paddr == sms_pkg::SMS_OFS_PRESET6)
        preset6_reg <= wval[15:0];
      if (paddr == sms_pkg::SMS_OFS_PRESET7)
        preset7_reg <= wval[15:0];
    end
  end

  // Active combination taken at reset release and on a restart command
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      restart_reg <= 1'b1;
      comb_act_reg <= sms_pkg::SMS_RST_COMB;
    end
    else
    begin
      restart_reg <= wr_restart && wval[sms_pkg::SMS_RESTART_BIT];
      if (restart_reg)
        comb_act_reg <= comb_cfg_reg;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_reg <= '0;
      preset_speed_reg <= 16'h0000;
      fwd_lim_reg <= 9'h000;
      rev_lim_reg <= 9'h000;
      torque_out_reg <= 11'sh000;
      limited_n_reg <= 1'b1;
    end
    else
    begin
      sel_reg <= sel_next;
      preset_speed_reg <= preset_next;
      fwd_lim_reg <= fwd_lim;
      rev_lim_reg <= rev_lim;
      torque_out_reg <= torque_clip;
      limited_n_reg <= !(over_fwd || over_rev);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign sel_out = sel_reg;
  assign preset_speed = preset_speed_reg;
  assign fwd_limit_applied = fwd_lim_reg;
  assign rev_limit_applied = rev_lim_reg;
  assign torque_out = torque_out_reg;
  assign torque_limited_flag_n = limited_n_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence pins_steady;
    $stable(sync2_reg)[*3];
  endsequence

  comb_in_range_a: assert property (
    comb_act_reg >= sms_pkg::SMS_COMB_MIN && comb_act_reg <= sms_pkg::SMS_COMB_MAX)
    else $error("active combination outside 4 to B");

  comb_held_a: assert property (
    !restart_reg |=> $stable(comb_act_reg))
    else $error("combination changed without restart");

  idle_mode_a: assert property (
    pins_on == 3'b000 && comb_act_reg == 4'h5 |=>
      sel_reg.mode == sms_pkg::SMS_MD_POSITION)
    else $error("code 5 idle did not give position control");

  preset_rev_a: assert property (
    pins_steady ##0 pins_on.mode_switch_input && comb_act_reg <= 4'h6 |=>
      sel_reg.reverse_dir && sel_reg.preset_index[2])
    else $error("switch on did not give reverse preset");

  mode_pair_a: assert property (
    comb_act_reg == 4'h8 |=> sel_reg.mode ==
      ($past(pins_on.mode_switch_input) ? sms_pkg::SMS_MD_TORQUE : sms_pkg::SMS_MD_POSITION))
    else $error("code 8 mode wrong");

  clamp_mode_a: assert property (
    comb_act_reg == 4'ha && pins_on.mode_switch_input |=>
      sel_reg.mode == sms_pkg::SMS_MD_ZERO_CLAMP)
    else $error("zero clamp not selected");

  fwd_pick_a: assert property (
    pins_on.fwd_limit_select && fwd_ext_reg <= motor_max_reg |=>
      fwd_limit_applied == $past(fwd_ext_reg))
    else $error("forward external limit not applied");

  rev_pick_a: assert property (
    !pins_on.rev_limit_select && rev_int_reg <= motor_max_reg |=>
      rev_limit_applied == $past(rev_int_reg))
    else $error("reverse internal limit not applied");

  max_clip_a: assert property (
    (fwd_limit_applied <= motor_max_reg && rev_limit_applied <= motor_max_reg) ||
      $changed(motor_max_reg))
    else $error("applied limit above motor maximum");

  ext_range_a: assert property (
    fwd_ext_reg <= sms_pkg::SMS_LIM_MAX && rev_ext_reg <= sms_pkg::SMS_LIM_MAX)
    else $error("external limit above 400");

  limited_flag_a: assert property (
    over_fwd || over_rev |=> !torque_limited_flag_n && torque_out != $past(torque_req))
    else $error("limit not flagged or not applied");

  flag_clear_a: assert property (
    !(over_fwd || over_rev) |=> torque_limited_flag_n && torque_out == $past(torque_req))
    else $error("flag or clip active without limiting");

endmodule

`default_nettype wire

/* sms_pkg.sv */
// Package for the control-mode and torque-limit selection block.
// Assumes a single 100 MHz clock domain and an APB register port.
`default_nettype none
package sms_pkg;

  // Register byte offsets
  localparam logic [7:0] SMS_OFS_MODE_CFG = 8'h00;
  localparam logic [7:0] SMS_OFS_RESTART = 8'h04;
  localparam logic [7:0] SMS_OFS_FWD_INT = 8'h08;
  localparam logic [7:0] SMS_OFS_REV_INT = 8'h0c;
  localparam logic [7:0] SMS_OFS_FWD_EXT = 8'h10;
  localparam logic [7:0] SMS_OFS_REV_EXT = 8'h14;
  localparam logic [7:0] SMS_OFS_MOTOR_MAX = 8'h18;
  localparam logic [7:0] SMS_OFS_PRESET5 = 8'h1c;
  localparam logic [7:0] SMS_OFS_PRESET6 = 8'h20;
  localparam logic [7:0] SMS_OFS_PRESET7 = 8'h24;
  localparam logic [7:0] SMS_OFS_STATUS = 8'h28;

  // Field positions
  localparam int SMS_STS_MODE_LSB = 0;
  localparam int SMS_STS_PRESET_LSB = 4;
  localparam int SMS_STS_REV_BIT = 7;
  localparam int SMS_STS_LIMITED_BIT = 8;
  localparam int SMS_STS_COMB_LSB = 12;
  localparam int SMS_STS_FWDLIM_LSB = 16;
  localparam int SMS_RESTART_BIT = 0;

  // Widths and ranges
  localparam int SMS_LIM_W = 9;
  localparam int SMS_TQ_W = 11;
  localparam int SMS_SPD_W = 16;
  localparam logic [8:0] SMS_LIM_MAX = 9'h190;
  localparam logic [3:0] SMS_COMB_MIN = 4'h4;
  localparam logic [3:0] SMS_COMB_MAX = 4'hb;

  // Reset values
  localparam logic [3:0] SMS_RST_COMB = 4'h5;
  localparam logic [8:0] SMS_RST_FWD_INT = 9'h12c;
  localparam logic [8:0] SMS_RST_REV_INT = 9'h12c;
  localparam logic [8:0] SMS_RST_EXT = 9'h064;
  localparam logic [8:0] SMS_RST_MOTOR_MAX = 9'h12c;
  localparam logic [15:0] SMS_RST_PRESET = 16'h0000;

  typedef enum logic [2:0] {
    SMS_MD_SPEED = 3'b000,
    SMS_MD_PRESET = 3'b001,
    SMS_MD_POSITION = 3'b010,
    SMS_MD_TORQUE = 3'b011,
    SMS_MD_ZERO_CLAMP = 3'b100,
    SMS_MD_POS_INHIBIT = 3'b101
  } sms_mode_t;

  // Synchronised inputs, true means ON
  typedef struct packed {
    logic mode_switch_input;
    logic fwd_limit_select;
    logic rev_limit_select;
  } sms_pins_t;

  typedef struct packed {
    sms_mode_t mode;
    logic [2:0] preset_index;
    logic reverse_dir;
  } sms_sel_t;

endpackage

`default_nettype wire

/* test_sms_mode_torque_sel.sv */
// Self-checking bench for the control-mode and torque-limit selection block.
// Assumes the host model on the pins; this module is the APB master.
`timescale 1ns/10ps
`default_nettype none
module test_sms_mode_torque_sel;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sms_pkg::sms_pins_t pins_req = '0;
  logic sw_n;
  logic fwd_n;
  logic rev_n;
  logic signed [10:0] torque_req = 11'sh000;
  logic signed [10:0] torque_out;
  logic flag_n;
  sms_pkg::sms_sel_t sel_out;
  logic [15:0] preset_speed;
  logic [8:0] fwd_lim;
  logic [8:0] rev_lim;
  logic [31:0] rd_data;
  logic rd_err;
  logic [3:0] e;
  int fl;
  int rl;
  int n_errors = 0;
  int check_count = 0;
  logic [7:0] ra [6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv [6] = '{32'h5, 32'h12c, 32'h12c, 32'h64, 32'h64, 32'h12c};

  always #5 clk_sys = ~clk_sys;

  sms_host_model sms_host_model_i (.clk_sys(clk_sys), .req(pins_req),
    .mode_switch_input_n(sw_n), .fwd_limit_select_n(fwd_n), .rev_limit_select_n(rev_n));

  sms_mode_torque_sel sms_mode_torque_sel_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_switch_input_n(sw_n),
    .fwd_limit_select_n(fwd_n), .rev_limit_select_n(rev_n), .torque_req(torque_req),
    .torque_out(torque_out), .torque_limited_flag_n(flag_n), .sel_out(sel_out),
    .preset_speed(preset_speed), .fwd_limit_applied(fwd_lim), .rev_limit_applied(rev_lim));

  task automatic give_verdict;
  begin
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task automatic cyc(input int n);
  begin
    repeat (n) @(posedge clk_sys);
  end
  endtask

  // One APB transfer; entered right after a rising edge, leaves one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
  begin
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 10);
    if (pready !== 1'b1)
    begin
      n_errors++;
      $display("FAIL %0t no ready", $time);
      give_verdict();
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  end
  endtask

  function automatic logic [3:0] exp_sel(input int c, input int p);
    logic s;
  begin
    s = p[2];
    if (c < 7)
      exp_sel = (p == 0) ? {1'b0, c == 4 ? sms_pkg::SMS_MD_SPEED : c == 5 ?
        sms_pkg::SMS_MD_POSITION : sms_pkg::SMS_MD_TORQUE} : {s, sms_pkg::SMS_MD_PRESET};
    else if (c == 7)
      exp_sel = {1'b0, s ? sms_pkg::SMS_MD_SPEED : sms_pkg::SMS_MD_POSITION};
    else if (c == 8)
      exp_sel = {1'b0, s ? sms_pkg::SMS_MD_TORQUE : sms_pkg::SMS_MD_POSITION};
    else if (c == 9)
      exp_sel = {1'b0, s ? sms_pkg::SMS_MD_SPEED : sms_pkg::SMS_MD_TORQUE};
    else if (c == 10)
      exp_sel = {1'b0, s ? sms_pkg::SMS_MD_ZERO_CLAMP : sms_pkg::SMS_MD_SPEED};
    else
      exp_sel = {1'b0, s ? sms_pkg::SMS_MD_POS_INHIBIT : sms_pkg::SMS_MD_POSITION};
  end
  endfunction

  initial
  begin
    cyc(16);
    arst_n <= 1'b1;
    cyc(2);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd_data, rv[i]);
    end
    apb(1'b0, 8'h2c, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    for (int k = 5; k < 8; k++)
      apb(1'b1, sms_pkg::SMS_OFS_PRESET5 + 8'(4 * (k - 5)), 32'h0101 * k);
    // Every combination code against every pin pattern
    for (int c = 4; c < 12; c++)
    begin
      apb(1'b1, sms_pkg::SMS_OFS_MODE_CFG, 32'(c));
      apb(1'b0, sms_pkg::SMS_OFS_STATUS, 32'h0);
      chk(32'(rd_data[15:12]), (c == 4) ? 32'h5 : 32'(c - 1));
      apb(1'b1, sms_pkg::SMS_OFS_RESTART, 32'h1);
      for (int p = 0; p < 8; p++)
      begin
        pins_req <= p[2:0];
        cyc(6);
        e = exp_sel(c, p);
        chk(32'(sel_out.mode), 32'(e[2:0]));
        chk(32'(sel_out.reverse_dir), 32'(e[3]));
        if (e[2:0] == sms_pkg::SMS_MD_PRESET)
          chk({13'h0, sel_out.preset_index, preset_speed},
            {13'h0, p[2:0], (p > 4) ? 16'(16'h0101 * p) : 16'h0});
      end
    end
    apb(1'b1, sms_pkg::SMS_OFS_MODE_CFG, 32'h3);
    chk({31'h0, rd_err}, 32'h1);
    apb(1'b0, sms_pkg::SMS_OFS_MODE_CFG, 32'h0);
    chk(rd_data, 32'hb);
    // Torque limits: reverse external above the motor maximum
    apb(1'b1, sms_pkg::SMS_OFS_FWD_INT, 32'h0000_00c8);
    apb(1'b1, sms_pkg::SMS_OFS_REV_INT, 32'h0000_0096);
    apb(1'b1, sms_pkg::SMS_OFS_FWD_EXT, 32'h0000_0032);
    apb(1'b1, sms_pkg::SMS_OFS_REV_EXT, 32'h0000_015e);
    for (int p = 0; p < 4; p++)
    begin
      pins_req <= p[2:0];
      cyc(6);
      fl = p[1] ? 50 : 200;
      rl = p[0] ? 300 : 150;
      chk(32'(fwd_lim), 32'(fl));
      chk(32'(rev_lim), 32'(rl));
      for (int t = 0; t < 4; t++)
      begin
        torque_req <= 11'((t < 2) ? fl + t : -(rl + t - 2));
        cyc(2);
        chk(32'(torque_out), (t < 2) ? fl : -rl);
        chk({31'h0, flag_n}, {31'h0, ~t[0]});
      end
    end
    apb(1'b1, sms_pkg::SMS_OFS_FWD_EXT, 32'h0000_01f4);
    apb(1'b0, sms_pkg::SMS_OFS_FWD_EXT, 32'h0);
    chk(rd_data, 32'h0000_0190);
    chk(32'(fwd_lim), 32'h0000_012c);
    apb(1'b1, sms_pkg::SMS_OFS_MOTOR_MAX, 32'h0000_015e);
    cyc(2);
    chk(32'(fwd_lim), 32'h0000_015e);
    give_verdict();
  end
endmodule
`default_nettype wire
